//--- shared/t16cc_defines.vh
`ifndef T16CC_DEFINES_VH
`define T16CC_DEFINES_VH

// Data-space offsets of the timer registers.
`define T16CC_OFS_FLAGS 8'h36
`define T16CC_OFS_ENABLES 8'h6f
`define T16CC_OFS_CNT_LO 8'h84
`define T16CC_OFS_CNT_HI 8'h85
`define T16CC_OFS_CAP_LO 8'h86
`define T16CC_OFS_CAP_HI 8'h87
`define T16CC_OFS_CMPA_LO 8'h88
`define T16CC_OFS_CMPA_HI 8'h89
`define T16CC_OFS_CMPB_LO 8'h8a
`define T16CC_OFS_CMPB_HI 8'h8b

// I/O-space addresses sit this far below the data-space offsets.
`define T16CC_IO_SHIFT 8'h20
// The I/O space window covers only the lowest 64 addresses.
`define T16CC_IO_LIMIT 8'h40

// Bit positions shared by the flag and the enable register.
`define T16CC_BIT_CAP 5
`define T16CC_BIT_MATCH_B 2
`define T16CC_BIT_MATCH_A 1
`define T16CC_BIT_WRAP 0
`define T16CC_IMPL_MASK 8'h27

`define T16CC_RST_BYTE 8'h00
`define T16CC_RST_WORD 16'h0000
`define T16CC_ONE 16'h0001
`define T16CC_MAX 16'hffff
`define T16CC_TOP_8BIT 16'h00ff
`define T16CC_TOP_9BIT 16'h01ff
`define T16CC_TOP_10BIT 16'h03ff

// Waveform mode field codes.
`define T16CC_MODE_NORMAL 4'h0
`define T16CC_MODE_PC8 4'h1
`define T16CC_MODE_PC9 4'h2
`define T16CC_MODE_PC10 4'h3
`define T16CC_MODE_CTC_A 4'h4
`define T16CC_MODE_FAST8 4'h5
`define T16CC_MODE_FAST9 4'h6
`define T16CC_MODE_FAST10 4'h7
`define T16CC_MODE_PFC_CAP 4'h8
`define T16CC_MODE_PFC_A 4'h9
`define T16CC_MODE_PC_CAP 4'ha
`define T16CC_MODE_PC_A 4'hb
`define T16CC_MODE_CTC_CAP 4'hc
`define T16CC_MODE_FAST_CAP 4'he
`define T16CC_MODE_FAST_A 4'hf

`endif

//--- rtl/t16cc_match_unit.v
`timescale 1ns/1ps
`include "t16cc_defines.vh"

module t16cc_match_unit (
    input wire clock,
    input wire rst,
    input wire ce,
    input wire [15:0] counterVal,
    input wire [15:0] compareVal,
    input wire timerTick,
    input wire blocked,
    input wire forceStrobe,
    output wire matchHit,
    output reg pinOut_r
);
    // A hit is an unblocked tick on which counter and compare agree.
    assign matchHit = timerTick & ~blocked & (counterVal == compareVal);

    // The pin toggles on a real or forced match; a forced one raises no flag.
    always @(posedge clock) begin
        if (rst) begin
            pinOut_r <= 1'b0;
        end else if (ce) begin
            if (matchHit | forceStrobe) begin
                pinOut_r <= ~pinOut_r;
            end
        end
    end
endmodule // t16cc_match_unit

//--- rtl/t16cc_regs.v
// How it works
// - Each capture edge on pin or comparator copies the counter into the capture value, except while the capture value is top.
// - The capture value serves as counter top when the waveform mode selects it.
// - Capture reads are coherent through the shared temporary high-byte latch.
// - Compare writes stage the high byte and commit both bytes together.
// - One temporary high-byte latch serves all 16-bit registers.
// - Both compare values are compared on every timer tick; a match flags and drives a pin.
// - An interrupt is requested only with enable, global enable and flag all set.
// - Capture flag sets on capture, or on reaching top when capture is top.
// - Capture flag clears on vector execution or a written one.
// - Match flags set the cycle after a timer tick on which the counter equals the compare value.
// - A forced compare strobe never sets its match flag.
// - Match flags clear on vector execution or a written one.
// - Wrap flag sets on overflow in normal and clear-on-match modes, else by mode.
// - Wrap flag clears on vector execution or a written one.
// - Flag register answers at its data offset and twenty hex lower in I/O space.
// - The counter is read and written coherently through the temporary latch.
// - A counter write suppresses compare matches on the next timer tick.
`timescale 1ns/1ps
`include "t16cc_defines.vh"

module t16cc_regs (
    input wire clock,
    input wire rst,
    input wire ce,
    input wire [7:0] busAddr,
    input wire busIoSpace,
    input wire busWrite,
    input wire busRead,
    input wire [7:0] busWData,
    output reg [7:0] busRData_r,
    input wire timerTick,
    input wire [3:0] waveformModeField,
    input wire captureRisingEdge,
    input wire captureFromComparator,
    input wire captureInputPin,
    input wire comparatorOut,
    input wire forceMatchAStrobe,
    input wire forceMatchBStrobe,
    input wire globalIrqEnable,
    input wire vecAckCapture,
    input wire vecAckMatchA,
    input wire vecAckMatchB,
    input wire vecAckWrap,
    output reg irqCapture_r,
    output reg irqMatchA_r,
    output reg irqMatchB_r,
    output reg irqWrap_r,
    output wire compareOutPinA,
    output wire compareOutPinB,
    output reg [15:0] counterValue_r
);
    reg [7:0] tempHigh_r;
    reg [15:0] captureValue_r;
    reg [15:0] compareValueA_r;
    reg [15:0] compareValueB_r;
    reg [7:0] enables_r;
    reg captureEventFlag_r;
    reg matchAFlag_r;
    reg matchBFlag_r;
    reg wrapFlag_r;
    reg matchBlock_r;
    reg pinSync1_r;
    reg pinSync2_r;
    reg cmpSync1_r;
    reg cmpSync2_r;
    reg capPrev_r;

    wire [7:0] effAddr;
    wire [1:0] matchHit;
    wire [1:0] pinBus;
    wire [1:0] forceBus;
    wire [31:0] compareBus;
    wire capSrc;
    wire capEdge;
    wire captureEvent;
    wire counterTopHit;
    wire wrapEvent;
    wire nonPwmMode;
    wire wrFlags;
    wire wrEnables;
    wire wrCntLo;
    wire wrCapLo;
    wire wrCmpALo;
    wire wrCmpBLo;
    wire wrAnyHigh;
    wire rdCntLo;
    wire rdCapLo;
    wire [7:0] flagsView;
    wire [7:0] flagsClear;

    reg [15:0] topValue;
    reg topFromCapture;
    reg wrapAtMax;
    reg [7:0] readMux;

    function regHit;
        input [7:0] addr;
        input [7:0] offset;
        begin
            regHit = (addr == offset);
        end
    endfunction

    // I/O-space accesses move up into data space; beyond the window they hit nothing.
    assign effAddr = !busIoSpace ? busAddr :
        (busAddr < `T16CC_IO_LIMIT) ? (busAddr + `T16CC_IO_SHIFT) : `T16CC_RST_BYTE;

    assign wrFlags = busWrite & regHit(effAddr, `T16CC_OFS_FLAGS);
    assign wrEnables = busWrite & regHit(effAddr, `T16CC_OFS_ENABLES);
    assign wrCntLo = busWrite & regHit(effAddr, `T16CC_OFS_CNT_LO);
    assign wrCapLo = busWrite & regHit(effAddr, `T16CC_OFS_CAP_LO);
    assign wrCmpALo = busWrite & regHit(effAddr, `T16CC_OFS_CMPA_LO);
    assign wrCmpBLo = busWrite & regHit(effAddr, `T16CC_OFS_CMPB_LO);
    assign wrAnyHigh = busWrite & (regHit(effAddr, `T16CC_OFS_CNT_HI) |
        regHit(effAddr, `T16CC_OFS_CAP_HI) |
        regHit(effAddr, `T16CC_OFS_CMPA_HI) |
        regHit(effAddr, `T16CC_OFS_CMPB_HI));
    assign rdCntLo = busRead & regHit(effAddr, `T16CC_OFS_CNT_LO);
    assign rdCapLo = busRead & regHit(effAddr, `T16CC_OFS_CAP_LO);

    // Mode decode: top value, who supplies it, and where the wrap flag fires.
    always @* begin
        topValue = `T16CC_MAX;
        topFromCapture = 1'b0;
        wrapAtMax = 1'b0;
        case (waveformModeField)
            `T16CC_MODE_NORMAL: begin
                wrapAtMax = 1'b1;
            end
            `T16CC_MODE_CTC_A: begin
                topValue = compareValueA_r;
                wrapAtMax = 1'b1;
            end
            `T16CC_MODE_CTC_CAP: begin
                topValue = captureValue_r;
                topFromCapture = 1'b1;
                wrapAtMax = 1'b1;
            end
            `T16CC_MODE_PC8, `T16CC_MODE_FAST8: begin
                topValue = `T16CC_TOP_8BIT;
            end
            `T16CC_MODE_PC9, `T16CC_MODE_FAST9: begin
                topValue = `T16CC_TOP_9BIT;
            end
            `T16CC_MODE_PC10, `T16CC_MODE_FAST10: begin
                topValue = `T16CC_TOP_10BIT;
            end
            `T16CC_MODE_PFC_CAP, `T16CC_MODE_PC_CAP, `T16CC_MODE_FAST_CAP: begin
                topValue = captureValue_r;
                topFromCapture = 1'b1;
            end
            `T16CC_MODE_PFC_A, `T16CC_MODE_PC_A, `T16CC_MODE_FAST_A: begin
                topValue = compareValueA_r;
            end
            default: begin
                topValue = `T16CC_MAX;
            end
        endcase
    end

    assign nonPwmMode = wrapAtMax;
    assign counterTopHit = timerTick & (counterValue_r == topValue);
    assign wrapEvent = wrapAtMax ? (timerTick & (counterValue_r == `T16CC_MAX)) :
        counterTopHit;

    // Capture source selection and edge detection on synchronised inputs.
    assign capSrc = captureFromComparator ? cmpSync2_r : pinSync2_r;
    assign capEdge = captureRisingEdge ? (capSrc & ~capPrev_r) : (~capSrc & capPrev_r);
    // The pin is disconnected while the capture value acts as top.
    assign captureEvent = capEdge & ~topFromCapture;

    always @(posedge clock) begin
        if (rst) begin
            pinSync1_r <= 1'b0;
            pinSync2_r <= 1'b0;
            cmpSync1_r <= 1'b0;
            cmpSync2_r <= 1'b0;
            capPrev_r <= 1'b0;
        end else if (ce) begin
            pinSync1_r <= captureInputPin;
            pinSync2_r <= pinSync1_r;
            cmpSync1_r <= comparatorOut;
            cmpSync2_r <= cmpSync1_r;
            capPrev_r <= capSrc;
        end
    end

    // Shared temporary high byte: loaded by any high-byte write or a counter or capture low-byte read.
    always @(posedge clock) begin
        if (rst) begin
            tempHigh_r <= `T16CC_RST_BYTE;
        end else if (ce) begin
            if (wrAnyHigh) begin
                tempHigh_r <= busWData;
            end else if (rdCntLo) begin
                tempHigh_r <= counterValue_r[15:8];
            end else if (rdCapLo) begin
                tempHigh_r <= captureValue_r[15:8];
            end
        end
    end

    // Counter: a CPU write commits both bytes and outranks the tick.
    always @(posedge clock) begin
        if (rst) begin
            counterValue_r <= `T16CC_RST_WORD;
            matchBlock_r <= 1'b0;
        end else if (ce) begin
            if (wrCntLo) begin
                counterValue_r <= {tempHigh_r, busWData};
                matchBlock_r <= 1'b1;
            end else if (timerTick) begin
                matchBlock_r <= 1'b0;
                if (counterTopHit) begin
                    counterValue_r <= `T16CC_RST_WORD;
                end else begin
                    counterValue_r <= counterValue_r + `T16CC_ONE;
                end
            end
        end
    end

    // Capture value: CPU write wins over a capture in the same cycle.
    always @(posedge clock) begin
        if (rst) begin
            captureValue_r <= `T16CC_RST_WORD;
        end else if (ce) begin
            if (wrCapLo) begin
                captureValue_r <= {tempHigh_r, busWData};
            end else if (captureEvent) begin
                captureValue_r <= counterValue_r;
            end
        end
    end

    // Compare values change on the low-byte write only, both bytes at once.
    always @(posedge clock) begin
        if (rst) begin
            compareValueA_r <= `T16CC_RST_WORD;
            compareValueB_r <= `T16CC_RST_WORD;
        end else if (ce) begin
            if (wrCmpALo) begin
                compareValueA_r <= {tempHigh_r, busWData};
            end
            if (wrCmpBLo) begin
                compareValueB_r <= {tempHigh_r, busWData};
            end
        end
    end

    assign compareBus = {compareValueB_r, compareValueA_r};
    assign forceBus = {forceMatchBStrobe & nonPwmMode, forceMatchAStrobe & nonPwmMode};

    genvar ch;
    generate
        for (ch = 0; ch < 2; ch = ch + 1) begin : gMatch
            t16cc_match_unit uMatch (
                .clock(clock),
                .rst(rst),
                .ce(ce),
                .counterVal(counterValue_r),
                .compareVal(compareBus[16*ch +: 16]),
                .timerTick(timerTick),
                .blocked(matchBlock_r),
                .forceStrobe(forceBus[ch]),
                .matchHit(matchHit[ch]),
                .pinOut_r(pinBus[ch])
            );
        end
    endgenerate

    assign compareOutPinA = pinBus[0];
    assign compareOutPinB = pinBus[1];

    always @(posedge clock) begin
        if (rst) begin
            enables_r <= `T16CC_RST_BYTE;
        end else if (ce && wrEnables) begin
            enables_r <= busWData & `T16CC_IMPL_MASK;
        end
    end

    // Only ones clear; a set in the same cycle wins over the clear.
    assign flagsClear = wrFlags ? busWData : `T16CC_RST_BYTE;

    always @(posedge clock) begin
        if (rst) begin
            captureEventFlag_r <= 1'b0;
            matchAFlag_r <= 1'b0;
            matchBFlag_r <= 1'b0;
            wrapFlag_r <= 1'b0;
        end else if (ce) begin
            captureEventFlag_r <= captureEvent | (counterTopHit & topFromCapture) |
                (captureEventFlag_r & ~flagsClear[`T16CC_BIT_CAP] &
                ~vecAckCapture);
            matchAFlag_r <= matchHit[0] |
                (matchAFlag_r & ~flagsClear[`T16CC_BIT_MATCH_A] &
                ~vecAckMatchA);
            matchBFlag_r <= matchHit[1] |
                (matchBFlag_r & ~flagsClear[`T16CC_BIT_MATCH_B] &
                ~vecAckMatchB);
            wrapFlag_r <= wrapEvent |
                (wrapFlag_r & ~flagsClear[`T16CC_BIT_WRAP] &
                ~vecAckWrap);
        end
    end

    // Requests need the enable, the global enable and the flag together.
    always @(posedge clock) begin
        if (rst) begin
            irqCapture_r <= 1'b0;
            irqMatchA_r <= 1'b0;
            irqMatchB_r <= 1'b0;
            irqWrap_r <= 1'b0;
        end else if (ce) begin
            irqCapture_r <= enables_r[`T16CC_BIT_CAP] & globalIrqEnable &
                captureEventFlag_r;
            irqMatchA_r <= enables_r[`T16CC_BIT_MATCH_A] & globalIrqEnable &
                matchAFlag_r;
            irqMatchB_r <= enables_r[`T16CC_BIT_MATCH_B] & globalIrqEnable &
                matchBFlag_r;
            irqWrap_r <= enables_r[`T16CC_BIT_WRAP] & globalIrqEnable &
                wrapFlag_r;
        end
    end

    assign flagsView = {2'b00, captureEventFlag_r, 2'b00, matchBFlag_r,
        matchAFlag_r, wrapFlag_r};

    // High bytes of counter and capture come from the latch, not live.
    always @* begin
        readMux = `T16CC_RST_BYTE;
        case (effAddr)
            `T16CC_OFS_FLAGS: readMux = flagsView;
            `T16CC_OFS_ENABLES: readMux = enables_r;
            `T16CC_OFS_CNT_LO: readMux = counterValue_r[7:0];
            `T16CC_OFS_CNT_HI: readMux = tempHigh_r;
            `T16CC_OFS_CAP_LO: readMux = captureValue_r[7:0];
            `T16CC_OFS_CAP_HI: readMux = tempHigh_r;
            `T16CC_OFS_CMPA_LO: readMux = compareValueA_r[7:0];
            `T16CC_OFS_CMPA_HI: readMux = compareValueA_r[15:8];
            `T16CC_OFS_CMPB_LO: readMux = compareValueB_r[7:0];
            `T16CC_OFS_CMPB_HI: readMux = compareValueB_r[15:8];
            default: readMux = `T16CC_RST_BYTE;
        endcase
    end

    always @(posedge clock) begin
        if (rst) begin
            busRData_r <= `T16CC_RST_BYTE;
        end else if (ce && busRead) begin
            busRData_r <= readMux;
        end
    end
endmodule // t16cc_regs

//--- test/t16cc_regs_sva.sv
`timescale 1ns/1ps
module t16cc_regs_sva (
    input wire clock,
    input wire rst,
    input wire ce,
    input wire [7:0] busAddr,
    input wire busIoSpace,
    input wire busWrite,
    input wire busRead,
    input wire [7:0] busRData_r,
    input wire timerTick,
    input wire [3:0] waveformModeField,
    input wire forceMatchAStrobe,
    input wire globalIrqEnable,
    input wire vecAckMatchA,
    input wire vecAckMatchB,
    input wire vecAckWrap,
    input wire irqCapture_r,
    input wire irqMatchA_r,
    input wire irqMatchB_r,
    input wire irqWrap_r,
    input wire compareOutPinA,
    input wire [15:0] counterValue_r
);
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (rst);

    sequence s_cnt_write;
        ce && busWrite && !busIoSpace && busAddr == 8'h84;
    endsequence

    // An acknowledge with no tick beside it, followed by one running cycle.
    sequence s_ack(logic ack);
        (ack && ce && !timerTick) ##1 ce;
    endsequence

    a_pin_a_cause: assert property (
        $changed(compareOutPinA) |-> $past(ce && (timerTick || forceMatchAStrobe)))
        else $error("pin A toggled without tick or force");
    a_force_toggles: assert property (
        ce && forceMatchAStrobe && !timerTick && waveformModeField == 4'h0
        |=> $changed(compareOutPinA))
        else $error("force strobe did not toggle pin A");
    a_write_blocks_match: assert property (
        s_cnt_write ##1 (ce && timerTick && !forceMatchAStrobe) |=> $stable(compareOutPinA))
        else $error("match not blocked after counter write");
    a_irq_global_gate: assert property (
        ce && !globalIrqEnable |=> !(irqCapture_r || irqMatchA_r || irqMatchB_r || irqWrap_r))
        else $error("request raised without global enable");
    a_ack_clears_a: assert property (s_ack(vecAckMatchA) |=> !irqMatchA_r)
        else $error("match A request survived acknowledge");
    a_ack_clears_b: assert property (s_ack(vecAckMatchB) |=> !irqMatchB_r)
        else $error("match B request survived acknowledge");
    a_ack_clears_wrap: assert property (s_ack(vecAckWrap) |=> !irqWrap_r)
        else $error("wrap request survived acknowledge");
    a_wrap_to_zero: assert property (
        ce && timerTick && !busWrite && counterValue_r == 16'hffff
        && waveformModeField inside {4'h0, 4'h4, 4'hc} |=> counterValue_r == 16'h0000)
        else $error("counter did not wrap at maximum");
    a_io_unmapped: assert property (
        ce && busRead && busIoSpace && busAddr == 8'h65 |=> busRData_r == 8'h00)
        else $error("I/O space reached a non-flag register");
    a_rdata_holds: assert property (!(ce && busRead) |=> $stable(busRData_r))
        else $error("read data changed without a read");
endmodule // t16cc_regs_sva

bind t16cc_regs t16cc_regs_sva i_sva (.clock(clock), .rst(rst), .ce(ce), .busAddr(busAddr),
    .busIoSpace(busIoSpace), .busWrite(busWrite), .busRead(busRead), .busRData_r(busRData_r),
    .timerTick(timerTick), .waveformModeField(waveformModeField),
    .forceMatchAStrobe(forceMatchAStrobe), .globalIrqEnable(globalIrqEnable),
    .vecAckMatchA(vecAckMatchA), .vecAckMatchB(vecAckMatchB), .vecAckWrap(vecAckWrap),
    .irqCapture_r(irqCapture_r), .irqMatchA_r(irqMatchA_r), .irqMatchB_r(irqMatchB_r),
    .irqWrap_r(irqWrap_r), .compareOutPinA(compareOutPinA), .counterValue_r(counterValue_r));

//--- test/t16cc_cpu_model.sv
`timescale 1ns/1ps
module t16cc_cpu_model (
    input wire clock,
    input wire [7:0] busRData_r,
    output logic [7:0] busAddr = 8'h00,
    output logic busIoSpace = 1'b0,
    output logic busWrite = 1'b0,
    output logic busRead = 1'b0,
    output logic [7:0] busWData = 8'h00
);
    // One access: held for one edge, then address and data released to their inverse.
    task automatic acc(input logic w, input logic io, input logic [7:0] a,
                       input logic [7:0] d, output logic [7:0] q);
        @(posedge clock);
        busAddr <= a;
        busIoSpace <= io;
        busWData <= d;
        busWrite <= w;
        busRead <= !w;
        @(posedge clock);
        busWrite <= 1'b0;
        busRead <= 1'b0;
        busAddr <= ~a;
        busWData <= ~d;
        #1 q = busRData_r;
    endtask

    task automatic wr16(input logic [7:0] lo, input logic [15:0] v);
        logic [7:0] q;
        acc(1'b1, 1'b0, lo + 8'h01, v[15:8], q);
        acc(1'b1, 1'b0, lo, v[7:0], q);
    endtask

    task automatic rd16(input logic [7:0] lo, output logic [15:0] v);
        acc(1'b0, 1'b0, lo, 8'h00, v[7:0]);
        acc(1'b0, 1'b0, lo + 8'h01, 8'h00, v[15:8]);
    endtask
endmodule // t16cc_cpu_model

//--- test/tb_top.sv
`timescale 1ns/1ps
module tb_top;
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic ce = 1'b1;
    localparam int TICK = 0, FRC_A = 1, FRC_B = 2, ACK_CAP = 3, ACK_A = 4, ACK_B = 5, ACK_WRAP = 6;
    logic [6:0] strobes = 7'h00;
    wire timerTick = strobes[TICK];
    logic [3:0] waveformModeField = 4'h0;
    logic captureRisingEdge = 1'b1;
    logic captureFromComparator = 1'b0;
    logic captureInputPin = 1'b0;
    logic comparatorOut = 1'b0;
    wire forceMatchAStrobe = strobes[FRC_A];
    wire forceMatchBStrobe = strobes[FRC_B];
    logic globalIrqEnable = 1'b1;
    wire vecAckCapture = strobes[ACK_CAP];
    wire vecAckMatchA = strobes[ACK_A];
    wire vecAckMatchB = strobes[ACK_B];
    wire vecAckWrap = strobes[ACK_WRAP];
    wire [7:0] busAddr, busWData, busRData_r;
    wire busIoSpace, busWrite, busRead, irqCapture_r, irqMatchA_r, irqMatchB_r, irqWrap_r;
    wire compareOutPinA, compareOutPinB;
    wire [15:0] counterValue_r;
    int bad_count = 0;
    int cmp_count = 0;
    logic [15:0] v;
    logic [7:0] q;

    t16cc_cpu_model cpu (.clock(clock), .busRData_r(busRData_r), .busAddr(busAddr),
        .busIoSpace(busIoSpace), .busWrite(busWrite), .busRead(busRead), .busWData(busWData));
    t16cc_regs i_dut (.clock(clock), .rst(rst), .ce(ce), .busAddr(busAddr),
        .busIoSpace(busIoSpace), .busWrite(busWrite), .busRead(busRead), .busWData(busWData),
        .busRData_r(busRData_r), .timerTick(timerTick), .waveformModeField(waveformModeField),
        .captureRisingEdge(captureRisingEdge), .captureFromComparator(captureFromComparator),
        .captureInputPin(captureInputPin), .comparatorOut(comparatorOut),
        .forceMatchAStrobe(forceMatchAStrobe), .forceMatchBStrobe(forceMatchBStrobe),
        .globalIrqEnable(globalIrqEnable), .vecAckCapture(vecAckCapture),
        .vecAckMatchA(vecAckMatchA), .vecAckMatchB(vecAckMatchB), .vecAckWrap(vecAckWrap),
        .irqCapture_r(irqCapture_r), .irqMatchA_r(irqMatchA_r), .irqMatchB_r(irqMatchB_r),
        .irqWrap_r(irqWrap_r), .compareOutPinA(compareOutPinA),
        .compareOutPinB(compareOutPinB), .counterValue_r(counterValue_r));

    initial begin
        forever #25 clock = ~clock;
    end

    task chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            bad_count++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task wr(input logic io, input logic [7:0] a, input logic [7:0] d);
        cpu.acc(1'b1, io, a, d, q);
    endtask

    task rdc(input logic io, input logic [7:0] a, input logic [7:0] e);
        cpu.acc(1'b0, io, a, 8'h00, q);
        chk($sformatf("register %h", a), {8'h00, q}, {8'h00, e});
    endtask

    task pulse(input int s);
        @(posedge clock);
        strobes[s] <= 1'b1;
        @(posedge clock);
        strobes[s] <= 1'b0;
        #1;
    endtask

    task tick(input int n);
        repeat (n) pulse(TICK);
    endtask

    task automatic t_reset;
        logic [7:0] adr[12] = '{8'h36, 8'h6f, 8'h84, 8'h85, 8'h86, 8'h87, 8'h88, 8'h89,
                                8'h8a, 8'h8b, 8'h50, 8'h65};
        foreach (adr[i]) begin
            rdc(i == 11, adr[i], 8'h00);
        end
        wr(1'b0, 8'h6f, 8'hff);
        rdc(1'b0, 8'h6f, 8'h27);
        wr(1'b0, 8'h50, 8'hff);
        rdc(1'b0, 8'h50, 8'h00);
    endtask

    task t_wide;
        cpu.wr16(8'h88, 16'h1234);
        cpu.rd16(8'h88, v);
        chk("compare a", v, 16'h1234);
        wr(1'b0, 8'h89, 8'h77);
        rdc(1'b0, 8'h89, 8'h12);
        wr(1'b0, 8'h84, 8'h9a);
        chk("counter", counterValue_r, 16'h779a);
        rdc(1'b1, 8'h65, 8'h00);
        cpu.rd16(8'h84, v);
        chk("counter read", v, 16'h779a);
        cpu.wr16(8'h8a, 16'hbeef);
        cpu.rd16(8'h8a, v);
        chk("compare b", v, 16'hbeef);
    endtask

    task t_match;
        cpu.wr16(8'h88, 16'h0010);
        cpu.wr16(8'h8a, 16'h0011);
        v = {14'h0, compareOutPinB, compareOutPinA};
        cpu.wr16(8'h84, 16'h0010);
        strobes[TICK] <= 1'b1;
        @(posedge clock);
        strobes[TICK] <= 1'b0;
        rdc(1'b0, 8'h36, 8'h00);
        tick(1);
        rdc(1'b0, 8'h36, 8'h04);
        chk("pins", {14'h0, compareOutPinB, compareOutPinA}, v ^ 16'h0002);
        chk("irq b", {15'h0, irqMatchB_r}, 16'h0001);
        wr(1'b0, 8'h36, 8'h00);
        rdc(1'b0, 8'h36, 8'h04);
        wr(1'b0, 8'h36, 8'h04);
        rdc(1'b0, 8'h36, 8'h00);
        cpu.wr16(8'h84, 16'h000e);
        tick(3);
        rdc(1'b0, 8'h36, 8'h02);
        @(posedge clock);
        globalIrqEnable <= 1'b0;
        repeat (2) @(posedge clock);
        #1 chk("irq a", {15'h0, irqMatchA_r}, 16'h0000);
        globalIrqEnable <= 1'b1;
        pulse(ACK_A);
        rdc(1'b0, 8'h36, 8'h00);
    endtask

    task t_force;
        v = {14'h0, compareOutPinB, compareOutPinA};
        pulse(FRC_A);
        pulse(FRC_B);
        chk("forced pins", {14'h0, compareOutPinB, compareOutPinA}, v ^ 16'h0003);
        rdc(1'b0, 8'h36, 8'h00);
        pulse(ACK_B);
    endtask

    task automatic t_wrap;
        logic [3:0] md[3] = '{4'h0, 4'h4, 4'hc};
        foreach (md[i]) begin
            waveformModeField <= md[i];
            cpu.wr16(8'h84, 16'hfffe);
            tick(2);
            chk("wrapped counter", counterValue_r, 16'h0000);
            rdc(1'b1, 8'h16, 8'h01);
            chk("irq wrap", {15'h0, irqWrap_r}, 16'h0001);
            pulse(ACK_WRAP);
            rdc(1'b0, 8'h36, 8'h00);
        end
        cpu.wr16(8'h84, 16'hffff);
        tick(1);
        wr(1'b1, 8'h16, 8'h01);
        rdc(1'b0, 8'h36, 8'h00);
        waveformModeField <= 4'h1;
        cpu.wr16(8'h84, 16'h00fe);
        tick(2);
        chk("8-bit top", counterValue_r, 16'h0000);
        rdc(1'b0, 8'h36, 8'h01);
        wr(1'b0, 8'h36, 8'h01);
        waveformModeField <= 4'h0;
    endtask

    task t_capture;
        cpu.wr16(8'h84, 16'h0321);
        captureInputPin <= 1'b1;
        repeat (5) @(posedge clock);
        cpu.rd16(8'h86, v);
        chk("pin capture", v, 16'h0321);
        rdc(1'b0, 8'h36, 8'h20);
        chk("irq capture", {15'h0, irqCapture_r}, 16'h0001);
        pulse(ACK_CAP);
        rdc(1'b0, 8'h36, 8'h00);
        captureFromComparator <= 1'b1;
        cpu.wr16(8'h84, 16'h0456);
        wr(1'b0, 8'h36, 8'hff);
        comparatorOut <= 1'b1;
        repeat (5) @(posedge clock);
        cpu.rd16(8'h86, v);
        chk("comparator capture", v, 16'h0456);
        wr(1'b0, 8'h36, 8'h20);
        rdc(1'b0, 8'h36, 8'h00);
        waveformModeField <= 4'hc;
        cpu.wr16(8'h86, 16'h0020);
        cpu.wr16(8'h84, 16'h001e);
        tick(3);
        chk("counter at top", counterValue_r, 16'h0000);
        rdc(1'b0, 8'h36, 8'h20);
    endtask

    task final_report;
        $display("Comparisons %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    initial begin
        repeat (10) @(posedge clock);
        rst <= 1'b0;
        t_reset;
        t_wide;
        t_match;
        t_force;
        t_wrap;
        t_capture;
        final_report;
    end

    initial begin
        repeat (20000) @(posedge clock);
        bad_count++;
        final_report;
    end
endmodule // tb_top
